// File: design/camera_output_mode_config.sv
// Output mode, timing and readout configuration handler with Avalon-MM slave
//
// The address map and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/1ps
`include "camera_output_mode_params.svh"

module camera_output_mode_config (
    // Clock and reset
    input  wire logic                                  clk_i,
    input  wire logic                                  reset_i,
    // Avalon-MM slave
    input  wire logic [5:0]                            address_i,
    input  wire logic                                  read_i,
    input  wire logic                                  write_i,
    input  wire logic [31:0]                           writedata_i,
    output logic [31:0]                                readdata_o,
    output logic                                       waitrequest_o,
    // Sensor framing pins
    input  wire logic                                  line_valid_i,
    input  wire logic                                  frame_valid_i,
    // Configuration results
    output camera_output_mode_pkg::out_mode_type       out_mode_o,
    output camera_output_mode_pkg::sensor_cfg_type     sensor_cfg_o,
    output logic [31:0]                                frame_interval_o,
    output logic [31:0]                                exposure_o,
    output logic                                       pixel_valid_o
);
    import camera_output_mode_pkg::*;

    // ------------------------------------------------------------------
    // Bus handshake
    // ------------------------------------------------------------------
    // One wait cycle lets read data come from a flop without a long path.
    logic        ack_q;
    logic        wait_q;
    logic [31:0] rdata_q;
    logic        req;
    logic        wr_en;

    assign req   = read_i | write_i;
    assign wr_en = write_i & ack_q;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            ack_q  <= 1'b0;
            wait_q <= 1'b1;
        end else if (req && !ack_q) begin
            ack_q  <= 1'b1;
            wait_q <= 1'b0;
        end else begin
            ack_q  <= 1'b0;
            wait_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Settings
    // ------------------------------------------------------------------
    logic [1:0]  depth_q;
    logic        layout_q;
    logic        sqrt_q;
    logic [31:0] fit_req_q;
    logic [31:0] exp_req_q;
    logic [1:0]  order_q;
    logic        single_q;
    logic        global_q;
    logic        ext_trig_q;
    logic        err_q;
    logic        bad_d;

    logic [31:0] wd;
    assign wd = writedata_i;

    // Argument checks, one per command except interval and exposure
    always_comb begin
        bad_d = 1'b0;
        if (wr_en) begin
            case (address_i)
                `OFS_PIXEL_DEPTH: begin
                    bad_d = (wd > 32'h2);
                end
                `OFS_LAYOUT, `OFS_SQRT_COMPRESS: begin
                    bad_d = (wd > 32'h1);
                end
                `OFS_READOUT_ORDER: begin
                    // Order may not move while single-port is on
                    bad_d = (wd != 32'h0 && wd != 32'h2) || single_q;
                end
                `OFS_SINGLE_PORT: begin
                    bad_d = (wd > 32'h1) ||
                            (wd == 32'h1 &&
                             (order_q != `ORDER_TOP_BOTTOM ||
                              global_q || ext_trig_q));
                end
                `OFS_SHUTTER: begin
                    bad_d = (wd > 32'h1) || (wd == 32'h1 && single_q);
                end
                `OFS_EXT_TRIGGER: begin
                    bad_d = (wd > 32'h1) || (wd == 32'h1 && single_q);
                end
                default: begin
                    bad_d = 1'b0;
                end
            endcase
        end
    end

    // Refused arguments never reach a setting
    logic        wr_ok;
    assign wr_ok = wr_en & ~bad_d;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            depth_q <= `RST_PIXEL_DEPTH;
        end else if (wr_ok && address_i == `OFS_PIXEL_DEPTH) begin
            depth_q <= wd[1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            layout_q <= `RST_LAYOUT;
        end else if (wr_ok && address_i == `OFS_LAYOUT) begin
            layout_q <= wd[0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            sqrt_q <= `RST_SQRT;
        end else if (wr_ok && address_i == `OFS_SQRT_COMPRESS) begin
            sqrt_q <= wd[0];
        end
    end

    // ------------------------------------------------------------------
    // Requested interval and exposure
    // ------------------------------------------------------------------
    // Any value is kept as asked; the floors are applied when resolving
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            fit_req_q <= `RST_INTERVAL;
        end else if (wr_ok && address_i == `OFS_FRAME_INTERVAL) begin
            fit_req_q <= wd;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            exp_req_q <= `RST_EXPOSURE;
        end else if (wr_ok && address_i == `OFS_EXPOSURE) begin
            exp_req_q <= wd;
        end
    end

    // ------------------------------------------------------------------
    // Readout order, port mode, shutter and trigger
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            order_q <= `ORDER_MIDDLE_OUT;
        end else if (wr_ok && address_i == `OFS_READOUT_ORDER) begin
            order_q <= wd[1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            single_q <= 1'b0;
        end else if (wr_ok && address_i == `OFS_SINGLE_PORT) begin
            single_q <= wd[0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            global_q <= 1'b0;
        end else if (wr_ok && address_i == `OFS_SHUTTER) begin
            global_q <= wd[0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            ext_trig_q <= 1'b0;
        end else if (wr_ok && address_i == `OFS_EXT_TRIGGER) begin
            ext_trig_q <= wd[0];
        end
    end

    // Sticky refusal flag; a refusal in the clearing cycle still sets it
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            err_q <= 1'b0;
        end else if (bad_d) begin
            err_q <= 1'b1;
        end else if (wr_en && address_i == `OFS_STATUS &&
                     wd[`ST_CMD_ERROR_BIT]) begin
            err_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------------
    // Partly entered combinations read as invalid unless they match a table entry.
    out_mode_type mode_d;
    out_mode_type mode_q;

    always_comb begin
        mode_d = '0;
        case ({depth_q, layout_q, sqrt_q})
            {`DEPTH_16BIT, `LAYOUT_EXPANDED, 1'b0}: begin
                mode_d = '{1'b1, 1'b1, 1'b0, 5'h10, 4'h5};
            end
            {`DEPTH_8BIT, `LAYOUT_EXPANDED, 1'b0}: begin
                mode_d = '{1'b1, 1'b1, 1'b0, 5'h08, 4'ha};
            end
            {`DEPTH_8BIT, `LAYOUT_BASE, 1'b0}: begin
                mode_d = '{1'b1, 1'b0, 1'b0, 5'h08, 4'h2};
            end
            {`DEPTH_12BIT, `LAYOUT_BASE, 1'b1}: begin
                mode_d = '{1'b1, 1'b0, 1'b1, 5'h0c, 4'h2};
            end
            {`DEPTH_16BIT, `LAYOUT_BASE, 1'b0}: begin
                mode_d = '{1'b1, 1'b0, 1'b0, 5'h10, 4'h1};
            end
            default: begin
                // Compression stays off outside twelve-bit mode
                mode_d = '0;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            mode_q <= '0;
        end else begin
            mode_q <= mode_d;
        end
    end

    // ------------------------------------------------------------------
    // Applied interval and exposure
    // ------------------------------------------------------------------
    logic [31:0] fit_min;
    logic [31:0] fit_q;
    logic [31:0] exp_q;

    // Single-port halves the top rate, so the floor doubles
    assign fit_min = single_q ? (`MIN_INTERVAL_ROWS << 1) :
                                `MIN_INTERVAL_ROWS;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            fit_q <= `MIN_INTERVAL_ROWS;
        end else if (fit_req_q == 32'h0 || fit_req_q < fit_min) begin
            fit_q <= fit_min;
        end else begin
            fit_q <= fit_req_q;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            exp_q <= `MIN_EXPOSURE_ROWS;
        end else if (exp_req_q == 32'h0) begin
            exp_q <= `MIN_EXPOSURE_ROWS;
        end else begin
            exp_q <= exp_req_q;
        end
    end

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    logic [31:0] rd_d;

    always_comb begin
        rd_d = 32'h0;
        case (address_i)
            `OFS_PIXEL_DEPTH:    rd_d = {30'h0, depth_q};
            `OFS_LAYOUT:         rd_d = {31'h0, layout_q};
            `OFS_SQRT_COMPRESS:  rd_d = {31'h0, sqrt_q};
            `OFS_FRAME_INTERVAL: rd_d = fit_q;
            `OFS_EXPOSURE:       rd_d = exp_q;
            `OFS_READOUT_ORDER:  rd_d = {30'h0, order_q};
            `OFS_SINGLE_PORT:    rd_d = {31'h0, single_q};
            `OFS_SHUTTER:        rd_d = {31'h0, global_q};
            `OFS_EXT_TRIGGER:    rd_d = {31'h0, ext_trig_q};
            `OFS_STATUS: begin
                rd_d[`ST_MODE_VALID_BIT]          = mode_q.valid;
                rd_d[`ST_CMD_ERROR_BIT]           = err_q;
                rd_d[`ST_TAPS_LSB +: 4]           = mode_q.taps;
                rd_d[`ST_BITS_LSB +: 5]           = mode_q.pixel_bits;
            end
            default: rd_d = 32'h0;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rdata_q <= 32'h0;
        end else if (read_i && !ack_q) begin
            rdata_q <= rd_d;
        end
    end

    // ------------------------------------------------------------------
    // Framing
    // ------------------------------------------------------------------
    logic [1:0] lval_sync_q;
    logic [1:0] fval_sync_q;
    logic       pix_valid_q;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            lval_sync_q <= 2'h0;
            fval_sync_q <= 2'h0;
            pix_valid_q <= 1'b0;
        end else begin
            lval_sync_q <= {lval_sync_q[0], line_valid_i};
            fval_sync_q <= {fval_sync_q[0], frame_valid_i};
            pix_valid_q <= lval_sync_q[1] & fval_sync_q[1];
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    sensor_cfg_type cfg_q;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            cfg_q <= '{`ORDER_MIDDLE_OUT, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
        end else begin
            cfg_q.readout_order  <= order_q;
            cfg_q.single_port    <= single_q;
            cfg_q.raster_serial  <= single_q;
            cfg_q.viewer_reorder <= 1'b1;
            cfg_q.global_shutter <= global_q;
            cfg_q.ext_trigger    <= ext_trig_q;
        end
    end

    assign readdata_o       = rdata_q;
    assign waitrequest_o    = wait_q;
    assign out_mode_o       = mode_q;
    assign sensor_cfg_o     = cfg_q;
    assign frame_interval_o = fit_q;
    assign exposure_o       = exp_q;
    assign pixel_valid_o    = pix_valid_q;

endmodule : camera_output_mode_config

// File: design/camera_output_mode_params.svh
// Offsets, field positions, reset values and limits of the output mode block
`ifndef CAMERA_OUTPUT_MODE_PARAMS_SVH
`define CAMERA_OUTPUT_MODE_PARAMS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define OFS_PIXEL_DEPTH     6'h00
`define OFS_LAYOUT          6'h04
`define OFS_SQRT_COMPRESS   6'h08
`define OFS_FRAME_INTERVAL  6'h0c
`define OFS_EXPOSURE        6'h10
`define OFS_READOUT_ORDER   6'h14
`define OFS_SINGLE_PORT     6'h18
`define OFS_SHUTTER         6'h1c
`define OFS_EXT_TRIGGER     6'h20
`define OFS_STATUS          6'h24

// ----------------------------------------------------------------------
// Command argument codes
// ----------------------------------------------------------------------
`define DEPTH_8BIT          2'h0
`define DEPTH_16BIT         2'h1
`define DEPTH_12BIT         2'h2
`define LAYOUT_EXPANDED     1'h0
`define LAYOUT_BASE         1'h1
`define ORDER_MIDDLE_OUT    2'h0
`define ORDER_TOP_BOTTOM    2'h2

// ----------------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------------
`define ST_MODE_VALID_BIT   0
`define ST_CMD_ERROR_BIT    1
`define ST_TAPS_LSB         4
`define ST_BITS_LSB         8

// ----------------------------------------------------------------------
// Reset values and limits; interval and exposure values in sensor row times
// ----------------------------------------------------------------------
`define RST_PIXEL_DEPTH     2'h0
`define RST_LAYOUT          1'h0
`define RST_SQRT            1'h0
`define RST_INTERVAL        32'h0000_0000
`define RST_EXPOSURE        32'h0000_0000
`define MIN_INTERVAL_ROWS   32'h0000_0400
`define MIN_EXPOSURE_ROWS   32'h0000_0001

`endif

// File: design/camera_output_mode_pkg.sv
// Types shared by the output mode block and its users
package camera_output_mode_pkg;

    // Resolved serial video output format
    typedef struct packed {
        logic       valid;
        logic       expanded;
        logic       sqrt_en;
        logic [4:0] pixel_bits;
        logic [3:0] taps;
    } out_mode_type;

    // Readout and trigger settings seen by the sensor side
    typedef struct packed {
        logic [1:0] readout_order;
        logic       single_port;
        logic       raster_serial;
        logic       viewer_reorder;
        logic       global_shutter;
        logic       ext_trigger;
    } sensor_cfg_type;

endpackage : camera_output_mode_pkg

// File: dv/camera_host_model.sv
// Host side model issuing configuration commands over Avalon-MM
`timescale 1ns/1ps
module camera_host_model (
    // Clock
    input  wire logic        clk_i,
    // Avalon-MM master
    output logic [5:0]       address_o,
    output logic             read_o,
    output logic             write_o,
    output logic [31:0]      writedata_o,
    input  wire logic [31:0] readdata_i,
    input  wire logic        waitrequest_i
);
    logic hung;
    initial begin
        address_o = 6'h00;
        read_o = 1'b0;
        write_o = 1'b0;
        writedata_o = 32'h0;
        hung = 1'b0;
    end
    // Held until the edge that samples waitrequest low; bounded wait
    task automatic xfer(input logic w, input logic [5:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge clk_i);
        address_o <= a;
        read_o <= !w;
        write_o <= w;
        writedata_o <= d;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (waitrequest_i !== 1'b0 && n < 64);
        if (waitrequest_i !== 1'b0) hung = 1'b1;
        q = readdata_i;
        read_o <= 1'b0;
        write_o <= 1'b0;
    endtask : xfer
endmodule : camera_host_model

// File: dv/camera_output_mode_chk.sv
// Port checker for the output mode block, bound into the design
`timescale 1ns/1ps
module camera_output_mode_chk
    import camera_output_mode_pkg::*;
(
    // Clock and reset
    input wire logic           clk_i,
    input wire logic           reset_i,
    // Framing pins
    input wire logic           line_valid_i,
    input wire logic           frame_valid_i,
    // Results
    input wire out_mode_type   out_mode_o,
    input wire sensor_cfg_type sensor_cfg_o,
    input wire logic [31:0]    frame_interval_o,
    input wire logic [31:0]    exposure_o,
    input wire logic           pixel_valid_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    property p_map;
        out_mode_o.valid |-> out_mode_o[10:0]
            inside {11'h505, 11'h48a, 11'h082, 11'h2c2, 11'h101};
    endproperty
    a_map: assert property (p_map)
        else $error("mode code off table");
    property p_sqrt;
        out_mode_o.valid |->
            out_mode_o.sqrt_en == (out_mode_o.pixel_bits == 5'h0c);
    endproperty
    a_sqrt: assert property (p_sqrt) else $error("compression bad");
    property p_fit; frame_interval_o >= 32'h0000_0400; endproperty
    a_fit: assert property (p_fit) else $error("interval short");
    property p_exp; exposure_o >= 32'h0000_0001; endproperty
    a_exp: assert property (p_exp) else $error("exposure zero");
    // Interval follows the port enable within one edge
    property p_slow;
        sensor_cfg_o.single_port && $past(sensor_cfg_o.single_port)
            |-> frame_interval_o >= 32'h0000_0800;
    endproperty
    a_slow: assert property (p_slow) else $error("rate not halved");
    property p_rast;
        sensor_cfg_o.single_port |-> sensor_cfg_o.raster_serial
            && !sensor_cfg_o.global_shutter && !sensor_cfg_o.ext_trigger;
    endproperty
    a_rast: assert property (p_rast)
        else $error("single port setup bad");
    property p_view; sensor_cfg_o.viewer_reorder; endproperty
    a_view: assert property (p_view) else $error("viewer order");
    property p_enter;
        $rose(sensor_cfg_o.single_port) |-> sensor_cfg_o.readout_order == 2'h2;
    endproperty
    a_enter: assert property (p_enter) else $error("entry order");
    property p_order;
        $changed(sensor_cfg_o.readout_order) |->
            !sensor_cfg_o.single_port && !$past(sensor_cfg_o.single_port);
    endproperty
    a_order: assert property (p_order) else $error("order moved");
    property p_code; sensor_cfg_o.readout_order inside {2'h0, 2'h2}; endproperty
    a_code: assert property (p_code) else $error("order code");
    // Pin history is only meaningful three edges after reset
    logic [1:0] warm_q;
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            warm_q <= 2'h0;
        end else if (warm_q != 2'h3) begin
            warm_q <= warm_q + 2'h1;
        end
    end
    property p_pix;
        warm_q == 2'h3 |-> pixel_valid_o ==
            ($past(line_valid_i, 3) && $past(frame_valid_i, 3));
    endproperty
    a_pix: assert property (p_pix) else $error("pixel valid late");
endmodule : camera_output_mode_chk
bind camera_output_mode_config camera_output_mode_chk chk (.clk_i,
    .reset_i, .line_valid_i, .frame_valid_i, .out_mode_o, .sensor_cfg_o,
    .frame_interval_o, .exposure_o, .pixel_valid_o);

// File: dv/camera_output_mode_config_tb.sv
// Self-checking bench for the output mode block
`timescale 1ns/1ps
`include "camera_output_mode_params.svh"
module camera_output_mode_config_tb;
    import camera_output_mode_pkg::*;
    logic           clk_i, reset_i, read_i, write_i, waitrequest_o;
    logic           line_valid_i, frame_valid_i, pixel_valid_o, run;
    logic [5:0]     address_i;
    logic [31:0]    writedata_i, readdata_o, frame_interval_o, exposure_o;
    logic [31:0]    q, r, v, seed, pin_s;
    logic [11:0]    m;
    logic [2:0]     pipe;
    logic [2:0]     modes [5];
    out_mode_type   out_mode_o;
    sensor_cfg_type sensor_cfg_o;
    int             fails, checks_done;
    camera_output_mode_config uut (.clk_i, .reset_i, .address_i, .read_i,
        .write_i, .writedata_i, .readdata_o, .waitrequest_o, .line_valid_i,
        .frame_valid_i, .out_mode_o, .sensor_cfg_o, .frame_interval_o,
        .exposure_o, .pixel_valid_o);
    camera_host_model host (.clk_i, .address_o(address_i), .read_o(read_i),
        .write_o(write_i), .writedata_o(writedata_i),
        .readdata_i(readdata_o), .waitrequest_i(waitrequest_o));
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    // ----
    // Helpers
    // ----
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs
    function automatic logic [11:0] mode_exp(input logic [1:0] d,
                                             input logic l);
        logic [4:0] b;
        logic [3:0] t;
        b = (d == 2'h0) ? 5'h08 : (d == 2'h1) ? 5'h10 : 5'h0c;
        t = l ? ((d == 2'h1) ? 4'h1 : 4'h2) : ((d == 2'h0) ? 4'ha : 4'h5);
        return {1'b1, !l, d == 2'h2, b, t};
    endfunction : mode_exp
    task automatic check(input string nm, input logic [31:0] s, e);
        checks_done++;
        if (s !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask : check
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d, r);
    endtask : wr
    task automatic rd(input logic [5:0] a);
        host.xfer(1'b0, a, 32'h0, q);
    endtask : rd
    task automatic settle;
        repeat (3) @(negedge clk_i);
    endtask : settle
    // Refused write keeps the setting and raises the sticky error flag
    task automatic refuse(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] p;
        rd(a);
        p = q;
        wr(a, d);
        rd(a);
        check("kept", q, p);
        rd(`OFS_STATUS);
        check("err", {31'h0, q[1]}, 32'h1);
        wr(`OFS_STATUS, 32'h2);
        rd(`OFS_STATUS);
        check("err_clr", {31'h0, q[1]}, 32'h0);
    endtask : refuse
    task automatic end_sim;
        if (host.hung) fails++;
        if (fails == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : end_sim
    // Random framing pins; the valid output trails them by three edges
    always @(posedge clk_i) begin
        pin_s <= xs(pin_s);
        line_valid_i <= run & pin_s[3];
        frame_valid_i <= run & pin_s[9];
        pipe <= {pipe[1:0], line_valid_i & frame_valid_i};
    end
    always @(negedge clk_i) begin
        if (run) check("pix", {31'h0, pixel_valid_o}, {31'h0, pipe[2]});
    end
    // ----
    // Main sequence
    // ----
    initial begin
        seed = 32'hc944;
        pin_s = 32'hc944;
        run = 1'b0;
        fails = 0;
        checks_done = 0;
        reset_i = 1'b1;
        line_valid_i = 1'b0;
        frame_valid_i = 1'b0;
        pipe = 3'h0;
        modes = '{3'b010, 3'b000, 3'b001, 3'b101, 3'b011};
        repeat (2) @(posedge clk_i);
        reset_i <= 1'b0;
        run <= 1'b1;
        rd(`OFS_FRAME_INTERVAL);
        check("fit_rst", q, `MIN_INTERVAL_ROWS);
        rd(`OFS_EXPOSURE);
        check("exp_rst", q, `MIN_EXPOSURE_ROWS);
        check("cfg_rst", {25'h0, sensor_cfg_o}, 32'h04);
        for (int i = 0; i < 5; i++) begin
            wr(`OFS_PIXEL_DEPTH, {30'h0, modes[i][2:1]});
            wr(`OFS_LAYOUT, {31'h0, modes[i][0]});
            wr(`OFS_SQRT_COMPRESS, {31'h0, modes[i][2:1] == 2'h2});
            // Sensor clock lowering for the new mode lies off this block
            settle;
            m = mode_exp(modes[i][2:1], modes[i][0]);
            check("mode", {20'h0, out_mode_o}, {20'h0, m});
            rd(`OFS_STATUS);
            check("status", q, {19'h0, m[8:0], 4'h1});
        end
        wr(`OFS_SQRT_COMPRESS, 32'h1);
        settle;
        check("mode_bad", {20'h0, out_mode_o}, 32'h0);
        wr(`OFS_SQRT_COMPRESS, 32'h0);
        refuse(`OFS_PIXEL_DEPTH, 32'h3);
        refuse(`OFS_LAYOUT, 32'h2);
        refuse(`OFS_SQRT_COMPRESS, 32'h2);
        refuse(`OFS_READOUT_ORDER, 32'h1);
        refuse(`OFS_SHUTTER, 32'h2);
        rd(6'h3c);
        check("unmapped", q, 32'h0);
        wr(6'h3c, 32'h1);
        wr(`OFS_FRAME_INTERVAL, 32'h0);
        settle;
        check("fit_out", frame_interval_o, `MIN_INTERVAL_ROWS);
        wr(`OFS_FRAME_INTERVAL, 32'h5);
        rd(`OFS_FRAME_INTERVAL);
        check("fit_floor", q, `MIN_INTERVAL_ROWS);
        seed = xs(seed);
        v = {12'h0, seed[19:0]} | 32'h800;
        wr(`OFS_FRAME_INTERVAL, v);
        rd(`OFS_FRAME_INTERVAL);
        check("fit_rd", q, v);
        wr(`OFS_EXPOSURE, 32'h0);
        rd(`OFS_EXPOSURE);
        check("exp_min", q, `MIN_EXPOSURE_ROWS);
        seed = xs(seed);
        v = {24'h0, seed[7:0]} | 32'h1;
        wr(`OFS_EXPOSURE, v);
        rd(`OFS_EXPOSURE);
        check("exp_rd", q, v);
        settle;
        check("exp_out", exposure_o, v);
        refuse(`OFS_SINGLE_PORT, 32'h1);
        wr(`OFS_READOUT_ORDER, {30'h0, `ORDER_TOP_BOTTOM});
        wr(`OFS_SHUTTER, 32'h1);
        refuse(`OFS_SINGLE_PORT, 32'h1);
        wr(`OFS_SHUTTER, 32'h0);
        wr(`OFS_EXT_TRIGGER, 32'h1);
        refuse(`OFS_SINGLE_PORT, 32'h1);
        wr(`OFS_EXT_TRIGGER, 32'h0);
        wr(`OFS_SINGLE_PORT, 32'h1);
        settle;
        check("cfg_sp", {25'h0, sensor_cfg_o}, 32'h5c);
        wr(`OFS_FRAME_INTERVAL, 32'h0);
        rd(`OFS_FRAME_INTERVAL);
        check("fit_sp", q, 32'h800);
        refuse(`OFS_SHUTTER, 32'h1);
        refuse(`OFS_EXT_TRIGGER, 32'h1);
        refuse(`OFS_READOUT_ORDER, 32'h0);
        wr(`OFS_SINGLE_PORT, 32'h0);
        wr(`OFS_READOUT_ORDER, {30'h0, `ORDER_MIDDLE_OUT});
        settle;
        check("cfg_il", {25'h0, sensor_cfg_o}, 32'h04);
        end_sim;
    end
endmodule : camera_output_mode_config_tb
